// >>> core/fif_pkg.sv
// Package for the fault interrupt flag block: offsets, field positions, timing.
// Assumes a 200 MHz system clock and an 8-bit register port inside the device.
package fif_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FIF_ADDR_IND_CFG = 8'h24;
    localparam logic [7:0] FIF_ADDR_MASK = 8'h25;
    localparam logic [7:0] FIF_ADDR_FLAGS_PRI = 8'h26;
    localparam logic [7:0] FIF_ADDR_FLAGS_HALT = 8'h27;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FIF_RST_IND_CFG = 8'h00;
    localparam logic [7:0] FIF_RST_MASK = 8'h00;
    localparam logic [7:0] FIF_RST_FLAGS = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FIF_IND_MODE_LSB = 6;
    localparam int FIF_IND_MODE_MSB = 7;
    // Mask register
    localparam int FIF_M_OVER_CURRENT = 7;
    localparam int FIF_M_UNDERVOLT = 6;
    localparam int FIF_M_CLK_ERR_B = 5;
    localparam int FIF_M_OVER_TEMP = 4;
    localparam int FIF_M_BROWNOUT = 3;
    localparam int FIF_M_CLK_ERR_A = 2;
    localparam int FIF_M_MOD_HALT = 1;
    localparam int FIF_M_FRAME_HALT = 0;
    // Primary flag register
    localparam int FIF_F_OVER_CURRENT = 7;
    localparam int FIF_F_UNDERVOLT = 6;
    localparam int FIF_F_CLK_ERR_A = 5;
    localparam int FIF_F_OVER_TEMP = 4;
    localparam int FIF_F_BROWNOUT = 3;
    localparam int FIF_F_CLK_ERR_B = 2;
    localparam int FIF_F_CONV_DONE = 1;
    // Halt flag register
    localparam int FIF_F_FRAME_HALT = 7;
    localparam int FIF_F_MOD_HALT = 6;
    // Pin function selector value for interrupt output
    localparam logic [2:0] FIF_PIN_FUNC_IRQ = 3'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int FIF_CLK_MHZ = 200;
    localparam int FIF_PULSE_MS = 2;
    localparam int FIF_PERIOD_MS = 4;
    localparam int FIF_PULSE_CYC = FIF_PULSE_MS * FIF_CLK_MHZ * 1000;
    localparam int FIF_PERIOD_CYC = FIF_PERIOD_MS * FIF_CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FIF_IND_SINGLE,
        FIF_IND_REPEAT,
        FIF_IND_LEVEL,
        FIF_IND_RESERVED
    } fif_ind_mode_t;

    typedef struct packed {
        logic over_current;
        logic analog_undervolt;
        logic clock_error_a;
        logic clock_error_b;
        logic over_temperature;
        logic brownout;
        logic conversion_done;
        logic frame_clock_halt;
        logic modulator_halt;
    } fif_events_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fif_reg_req_t;

endpackage : fif_pkg

// >>> core/fif_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs from fault detectors outside this clock.
module fif_sync #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change accepted only once stages two and three agree
            out_q <= (agree & s3_q) | (~agree & out_q);
        end
    end

    assign dout = out_q;

endmodule : fif_sync

// >>> core/fif_core.sv
// Fault interrupt flags: sticky flags, source mask and interrupt pin indication.
// Assumes a host register port with one-cycle rd/wr strobes and fault levels
// arriving asynchronously from the detectors.
//
// Function
// R1 - Mode 0 gives one active-high pulse of 2 ms per new interrupt.
// R2 - Mode 1 gives 2 ms pulses every 4 ms until both flag registers are read clear.
// R3 - Mode 2 holds the pin high from the interrupt until both flag registers are read clear.
// R4 - The indication mode sits in bits 7 to 6 of the first config register, bits 5 to 0 reserved and zero.
// R5 - Each source has a mask bit in the second config register, 1 meaning used. Conversion-done has no mask bit here.
// R6 - Mask order is over-current, undervolt, clock error b, over-temp, brownout, clock error a, modulator, frame.
// R7 - All mask and indication bits reset to zero.
// R8 - Each flag is sticky and reads 1 if its condition occurred since the last read.
// R9 - Primary flag order is over-current, undervolt, clock error a, over-temp, brownout, clock error b, conversion.
// R10 - Reading the primary flag register clears it, and active conditions are caught again.
// R11 - The halt flag register holds frame halt in bit 7 and modulator halt in bit 6, rest zero.
// R12 - The host ends a pulsing or held indication by reading both flag registers.
// R13 - Indication shows on the pin only while the pin function selector is 1.
// R14 - A set flag with its mask bit set raises an interrupt, and mode 3 keeps the pin low.
// R15 - A condition arising in the cycle of a read stays set after the read.
module fif_core
    import fif_pkg::*;
#(
    parameter int PULSE_CYC = fif_pkg::FIF_PULSE_CYC,
    parameter int PERIOD_CYC = fif_pkg::FIF_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire fif_pkg::fif_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire fif_pkg::fif_events_t fault_events,
    input wire logic [2:0] pin_function,
    output logic irq_pin
);
    import fif_pkg::*;

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] PULSE_END = CW'(PULSE_CYC - 1);
    localparam logic [CW-1:0] PERIOD_END = CW'(PERIOD_CYC - 1);

    // ------------------------------------------------------------
    // Input crossing
    // ------------------------------------------------------------
    fif_events_t ev_sync;

    fif_sync #(
        .WIDTH($bits(fif_events_t))
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din(fault_events),
        .dout(ev_sync)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0] mode_q;
    logic [7:0] mask_q;
    logic [7:0] pri_q;
    logic [7:0] pri_d;
    logic [1:0] halt_q;
    logic [1:0] halt_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [2:0] pin_func_q;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] offset);
        return strobe && (addr == offset);
    endfunction : addr_hit

    wire wr_cfg = addr_hit(reg_req.wr, reg_req.addr, FIF_ADDR_IND_CFG);
    wire wr_mask = addr_hit(reg_req.wr, reg_req.addr, FIF_ADDR_MASK);
    wire rd_pri = addr_hit(reg_req.rd, reg_req.addr, FIF_ADDR_FLAGS_PRI);
    wire rd_halt = addr_hit(reg_req.rd, reg_req.addr, FIF_ADDR_FLAGS_HALT);

    // Event vector in primary register order
    logic [7:0] pri_ev;
    always_comb begin
        pri_ev = 8'h00;
        pri_ev[FIF_F_OVER_CURRENT] = ev_sync.over_current; // R9
        pri_ev[FIF_F_UNDERVOLT] = ev_sync.analog_undervolt;
        pri_ev[FIF_F_CLK_ERR_A] = ev_sync.clock_error_a;
        pri_ev[FIF_F_OVER_TEMP] = ev_sync.over_temperature;
        pri_ev[FIF_F_BROWNOUT] = ev_sync.brownout;
        pri_ev[FIF_F_CLK_ERR_B] = ev_sync.clock_error_b;
        pri_ev[FIF_F_CONV_DONE] = ev_sync.conversion_done;
    end
    wire [1:0] halt_ev = {ev_sync.frame_clock_halt, ev_sync.modulator_halt};

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // Set wins over the read clear, so no event is lost
    for (genvar b = 0; b < 8; b++) begin : g_pri_flag
        assign pri_d[b] = (rd_pri ? 1'b0 : pri_q[b]) | pri_ev[b]; // R8 R10 R15
    end
    for (genvar h = 0; h < 2; h++) begin : g_halt_flag
        assign halt_d[h] = (rd_halt ? 1'b0 : halt_q[h]) | halt_ev[h]; // R8 R15
    end

    // Halt register image
    logic [7:0] halt_img;
    always_comb begin
        halt_img = 8'h00;
        halt_img[FIF_F_FRAME_HALT] = halt_q[1]; // R11
        halt_img[FIF_F_MOD_HALT] = halt_q[0];
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        case (reg_req.addr)
            FIF_ADDR_IND_CFG: rdata_d = {mode_q, 6'h00}; // R4
            FIF_ADDR_MASK: rdata_d = mask_q;
            FIF_ADDR_FLAGS_PRI: rdata_d = pri_q;
            FIF_ADDR_FLAGS_HALT: rdata_d = halt_img;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q <= FIF_RST_IND_CFG[FIF_IND_MODE_MSB:FIF_IND_MODE_LSB]; // R7
            mask_q <= FIF_RST_MASK; // R7
            pri_q <= FIF_RST_FLAGS;
            halt_q <= 2'b00;
            rdata_q <= 8'h00;
            pin_func_q <= 3'h0;
        end else begin
            if (wr_cfg) begin
                mode_q <= reg_req.wdata[FIF_IND_MODE_MSB:FIF_IND_MODE_LSB]; // R4
            end
            if (wr_mask) begin
                mask_q <= reg_req.wdata; // R5
            end
            pri_q <= pri_d;
            halt_q <= halt_d;
            if (reg_req.rd) begin
                rdata_q <= rdata_d;
            end
            pin_func_q <= pin_function;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Interrupt generation
    // ------------------------------------------------------------
    // Conversion-done has no mask bit and so never raises the pin
    logic [7:0] masked_flags;
    always_comb begin
        masked_flags = 8'h00;
        masked_flags[FIF_M_OVER_CURRENT] = pri_q[FIF_F_OVER_CURRENT]; // R6
        masked_flags[FIF_M_UNDERVOLT] = pri_q[FIF_F_UNDERVOLT];
        masked_flags[FIF_M_CLK_ERR_B] = pri_q[FIF_F_CLK_ERR_B];
        masked_flags[FIF_M_OVER_TEMP] = pri_q[FIF_F_OVER_TEMP];
        masked_flags[FIF_M_BROWNOUT] = pri_q[FIF_F_BROWNOUT];
        masked_flags[FIF_M_CLK_ERR_A] = pri_q[FIF_F_CLK_ERR_A];
        masked_flags[FIF_M_MOD_HALT] = halt_q[0];
        masked_flags[FIF_M_FRAME_HALT] = halt_q[1];
    end

    wire irq_active = |(masked_flags & mask_q); // R5 R14
    logic irq_active_q;
    wire irq_rise = irq_active && !irq_active_q; // R14

    // ------------------------------------------------------------
    // Indication sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PULSE,
        ST_GAP,
        ST_WAIT
    } fif_ind_state_t;

    fif_ind_state_t state_q;
    fif_ind_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic pin_d;
    logic pin_q;
    fif_ind_mode_t mode_e;

    assign mode_e = fif_ind_mode_t'(mode_q);
    wire pin_enabled = (pin_func_q == FIF_PIN_FUNC_IRQ); // R13
    wire cnt_pulse_done = (cnt_q == PULSE_END);
    wire cnt_period_done = (cnt_q == PERIOD_END);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + CW'(1);
        pin_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                cnt_d = '0;
                if (irq_rise) begin
                    case (mode_e)
                        FIF_IND_SINGLE: state_d = ST_PULSE; // R1
                        FIF_IND_REPEAT: state_d = ST_PULSE; // R2
                        FIF_IND_LEVEL: state_d = ST_WAIT; // R3
                        default: state_d = ST_IDLE; // R14
                    endcase
                end
            end
            ST_PULSE: begin
                // Reserved mode written mid-pulse silences the pin at once
                pin_d = (mode_e != FIF_IND_RESERVED); // R14
                if (mode_e == FIF_IND_REPEAT && !irq_active) begin
                    state_d = ST_IDLE; // R2 R12
                end else if (cnt_pulse_done) begin
                    // Single mode waits for the flags to clear before re-arming
                    state_d = (mode_e == FIF_IND_REPEAT) ? ST_GAP : ST_WAIT; // R1
                end
            end
            ST_GAP: begin
                if (!irq_active) begin
                    state_d = ST_IDLE; // R2 R12
                end else if (cnt_period_done) begin
                    state_d = ST_PULSE; // R2
                    cnt_d = '0;
                end
            end
            ST_WAIT: begin
                cnt_d = '0;
                pin_d = (mode_e == FIF_IND_LEVEL); // R3
                if (!irq_active) begin
                    state_d = ST_IDLE; // R3 R12
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            pin_q <= 1'b0;
            irq_active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d && pin_enabled; // R13
            irq_active_q <= irq_active;
        end
    end

    assign irq_pin = pin_q;

endmodule : fif_core

// >>> tb/fif_core_sva.sv
// Checker for the fault interrupt flag block, bound into fif_core.
// Assumes registers change only through reg_req writes.
module fif_core_sva
    import fif_pkg::*;
#(
    parameter int PULSE_CYC = 20,
    parameter int PERIOD_CYC = 40
) (
    input wire logic clk,
    input wire logic reset,
    input wire fif_pkg::fif_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire fif_pkg::fif_events_t fault_events,
    input wire logic [2:0] pin_function,
    input wire logic irq_pin
);
    import fif_pkg::*;
    // ------
    // Shadow state
    // ------
    logic [1:0] mode_q;
    logic [7:0] mask_q;
    logic [2:0] rd_q;
    int hi_q;
    int lo_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q <= 2'h0;
            mask_q <= 8'h00;
            rd_q <= 3'h0;
            hi_q <= 0;
            lo_q <= 0;
        end else begin
            if (reg_req.wr && reg_req.addr == FIF_ADDR_IND_CFG) mode_q <= reg_req.wdata[7:6];
            if (reg_req.wr && reg_req.addr == FIF_ADDR_MASK) mask_q <= reg_req.wdata;
            rd_q <= {rd_q[1:0], reg_req.rd};
            hi_q <= irq_pin ? hi_q + 1 : 0;
            lo_q <= irq_pin ? 0 : lo_q + 1;
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_cfg_reserved_zero: assert property (reg_req.rd && reg_req.addr == FIF_ADDR_IND_CFG |=> reg_rdata[5:0] == 6'h00)
        else $error("config reserved bits set");
    a_halt_reserved_zero: assert property (reg_req.rd && reg_req.addr == FIF_ADDR_FLAGS_HALT |=> reg_rdata[5:0] == 6'h00)
        else $error("halt reserved bits set");
    a_pin_func_gate: assert property ((pin_function != FIF_PIN_FUNC_IRQ) [*3] |-> !irq_pin)
        else $error("pin high outside interrupt function");
    a_pulse_width_max: assert property (mode_q != 2'h2 |-> hi_q <= PULSE_CYC)
        else $error("pulse too long");
    a_repeat_gap: assert property ($rose(irq_pin) && mode_q == 2'h1 && lo_q < PERIOD_CYC |-> lo_q == PERIOD_CYC - PULSE_CYC)
        else $error("repeat gap wrong");
    a_mode3_low: assert property (mode_q == 2'h3 && $past(mode_q) == 2'h3 |-> !irq_pin)
        else $error("pin high in reserved mode");
    a_mask_off_quiet: assert property (!irq_pin && mask_q == 8'h00 |=> !irq_pin)
        else $error("pin rose with all sources masked");
    a_level_holds: assert property (irq_pin && mode_q == 2'h2 && rd_q == 3'h0 && !reg_req.rd |=> irq_pin)
        else $error("level dropped without a read");
    c_single: cover property ($rose(irq_pin) && mode_q == 2'h0);
    c_repeat: cover property ($rose(irq_pin) && mode_q == 2'h1);
    c_level: cover property ($rose(irq_pin) && mode_q == 2'h2);
endmodule : fif_core_sva

bind fif_core fif_core_sva #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) fif_core_sva_i (.clk(clk),
    .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .fault_events(fault_events),
    .pin_function(pin_function), .irq_pin(irq_pin));

// >>> tb/fif_host_model.sv
// Host side watcher of the interrupt pin: counts pulses, keeps last width.
// Assumes the pin is a flop output in the clk domain.
module fif_host_model (
    input wire logic clk,
    input wire logic irq_pin,
    output int rises,
    output int width
);
    timeunit 1ns;
    timeprecision 1ps;
    int run;
    logic last = 1'b0;
    // Falling edge, so the pin flop has settled
    always @(negedge clk) begin
        if (irq_pin === 1'b1) begin
            if (!last) rises++;
            run++;
        end else if (last) begin
            width = run;
            run = 0;
        end
        last = (irq_pin === 1'b1);
    end
endmodule : fif_host_model

// >>> tb/fif_core_tb.sv
// Testbench for fif_core: register tasks, fault stimulus, pin checks.
// Assumes fif_core_sva is bound and fif_host_model watches the pin.
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module fif_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fif_pkg::*;
    // Short counts keep the run small
    localparam int PULSE = 20;
    localparam int PERIOD = 40;
    // Per source: primary flags, halt flags, mask bit
    localparam logic [23:0] TBL [9] = '{24'h800080, 24'h400040, 24'h200004, 24'h040020,
        24'h100010, 24'h080008, 24'h020000, 24'h008001, 24'h004002};
    logic clk = 1'b0;
    logic reset = 1'b1;
    fif_reg_req_t req = '0;
    fif_events_t ev = '0;
    logic [2:0] pf = 3'h1;
    logic [7:0] rdata;
    logic irq;
    int rises;
    int width;
    int mismatches = 0;
    int total_checks = 0;
    int n0;
    fif_core #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) fif_core_i (.clk(clk), .reset(reset),
        .reg_req(req), .reg_rdata(rdata), .fault_events(ev), .pin_function(pf), .irq_pin(irq));
    fif_host_model fif_host_model_i (.clk(clk), .irq_pin(irq), .rises(rises), .width(width));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ------
    // Tasks
    // ------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        `CHK(rdata, e)
    endtask : rd
    task automatic trig(input logic [7:0] cfg);
        wr(FIF_ADDR_IND_CFG, cfg);
        n0 = rises;
        ev.brownout = 1'b1;
        cyc(8);
        ev = '0;
    endtask : trig
    task automatic ack();
        rd(FIF_ADDR_FLAGS_PRI, 8'h08);
        rd(FIF_ADDR_FLAGS_HALT, 8'h00);
    endtask : ack
    task automatic done(input string s);
        $display("test %s finished, %0d checks so far", s, total_checks);
    endtask : done
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    // ------
    // Tests
    // ------
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rd(FIF_ADDR_IND_CFG, 8'h00);
        rd(FIF_ADDR_MASK, 8'h00);
        rd(FIF_ADDR_FLAGS_PRI, 8'h00);
        rd(FIF_ADDR_FLAGS_HALT, 8'h00);
        wr(FIF_ADDR_IND_CFG, 8'hFF);
        rd(FIF_ADDR_IND_CFG, 8'hC0);
        wr(FIF_ADDR_MASK, 8'hA5);
        rd(FIF_ADDR_MASK, 8'hA5);
        wr(FIF_ADDR_FLAGS_PRI, 8'hFF);
        rd(FIF_ADDR_FLAGS_PRI, 8'h00);
        rd(8'h30, 8'h00);
        done("registers");
        wr(FIF_ADDR_IND_CFG, 8'h80);
        for (int i = 0; i < 9; i++) begin
            wr(FIF_ADDR_MASK, TBL[i][7:0]);
            ev = 9'h100 >> i;
            cyc(8);
            ev = '0;
            cyc(6);
            `CHK(irq, TBL[i][7:0] != 8'h00)
            rd(FIF_ADDR_FLAGS_PRI, TBL[i][23:16]);
            rd(FIF_ADDR_FLAGS_HALT, TBL[i][15:8]);
            cyc(6);
            `CHK(irq, 1'b0)
            rd(FIF_ADDR_FLAGS_PRI, 8'h00);
            rd(FIF_ADDR_FLAGS_HALT, 8'h00);
        end
        ev.brownout = 1'b1;
        cyc(8);
        rd(FIF_ADDR_FLAGS_PRI, 8'h08);
        rd(FIF_ADDR_FLAGS_PRI, 8'h08);
        ev = '0;
        cyc(8);
        rd(FIF_ADDR_FLAGS_PRI, 8'h08);
        rd(FIF_ADDR_FLAGS_PRI, 8'h00);
        done("flags");
        wr(FIF_ADDR_MASK, 8'h08);
        trig(8'h00);
        cyc(80);
        `CHK(rises - n0, 1)
        `CHK(width, PULSE)
        ack();
        trig(8'h40);
        cyc(142);
        `CHK(rises - n0, 4)
        `CHK(width, PULSE)
        ack();
        n0 = rises;
        cyc(100);
        `CHK(rises - n0, 0)
        trig(8'hC0);
        cyc(40);
        `CHK(rises - n0, 0)
        ack();
        pf = 3'h0;
        trig(8'h80);
        cyc(40);
        `CHK(irq, 1'b0)
        ack();
        pf = 3'h1;
        done("indication");
        conclude();
    end
    // Whole run needs about 800 cycles; allow plenty more
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule : fif_core_tb
